/* design/ppm_defs.svh */
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

// field positions inside the request argument for a card mode change
`define PPM_ARG_MIXED_BIT  2
`define PPM_ARG_FUNC0_BIT  1
`define PPM_ARG_FUNC1_BIT  0
// field position of the single flag carried by flag-style requests
`define PPM_ARG_FLAG_BIT   0
// reset values
`define PPM_FIXED_STUFF_RST 1'b1
`define PPM_ENH_FEC_RST     4'h0
`define PPM_PROV_RST        2'h0
`define PPM_FRAMING_OFF_RST 1'b0
// counts
`define PPM_NUM_PAIRS 2
`define PPM_NUM_PORTS 4

`endif

/* design/ppm_pkg.sv */
package ppm_pkg;

    typedef enum logic {
        func_transponder,
        func_regenerator
    } ppm_func_t;

    typedef enum logic [1:0] {
        dual_transponder_mode,
        dual_regenerator_mode,
        mixed_first_pair_transponder,
        mixed_first_pair_regenerator
    } ppm_card_mode_t;

    typedef enum logic [2:0] {
        pl_none,
        ten_gig_ethernet_payload,
        pl_otu2,
        pl_otu2e,
        pl_oc192,
        pl_stm64,
        pl_fc10g,
        pl_ib5
    } ppm_payload_t;

    typedef enum logic [2:0] {
        cmd_set_mode,
        cmd_provision,
        cmd_release,
        cmd_set_fec,
        cmd_fixed_stuff,
        cmd_framing_off,
        cmd_odu_transp
    } ppm_cmd_t;

    // trunk rates: off, 10.70923, 11.0491, 11.0957 Gbps
    typedef enum logic [1:0] {
        rate_off,
        rate_otu2_std,
        rate_otu2_oc_nofs,
        rate_otu2_oc_fs
    } ppm_rate_t;

    typedef enum logic [1:0] {
        odu_interop_none,
        odu_extended,
        odu_transparent
    } ppm_odu_t;

    typedef enum logic [2:0] {
        rej_none,
        rej_in_service,
        rej_mode_combo,
        rej_payload,
        rej_rate_locked,
        rej_fec_port,
        rej_not_allowed
    } ppm_rej_t;

endpackage : ppm_pkg

/* design/ppm_sticky.sv */
`timescale 1ns/1ps

// sticky flag; a set in the clearing cycle wins so no event is lost
module ppm_sticky (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);

    logic flag_q;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            flag_q <= 1'b0;
        else if (i_set)
            flag_q <= 1'b1;
        else if (i_clear)
            flag_q <= 1'b0;
    end

    assign o_flag = flag_q;

endmodule : ppm_sticky

/* design/ppm_pair_out.sv */
`timescale 1ns/1ps

// per-pair datapath controls, registered one cycle after the state
module ppm_pair_out (
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    input  ppm_pkg::ppm_func_t       i_func,
    input  wire logic                i_prov,
    input  ppm_pkg::ppm_payload_t    i_payload,
    input  wire logic                i_fixed_stuff,
    input  wire logic                i_framing_off,
    input  ppm_pkg::ppm_odu_t        i_odu,
    output ppm_pkg::ppm_rate_t       o_rate,
    output logic                     o_client_otu2e,
    output logic                     o_trunk_otu2e,
    output logic                     o_odu_terminate,
    output logic                     o_odu_passthru,
    output logic                     o_otn_active
);

    logic               otn;
    logic               eth;
    logic               reg_f;
    ppm_pkg::ppm_rate_t rate_d;

    // framing off removes every otu/odu interface of the pair
    assign otn   = i_prov && !i_framing_off; // R17
    assign eth   = (i_payload == ppm_pkg::ten_gig_ethernet_payload);
    assign reg_f = (i_func == ppm_pkg::func_regenerator);

    // sonet clients ride the standard rate, lan phy is overclocked
    always_comb
    begin
        rate_d = ppm_pkg::rate_otu2_std; // R8
        if (!otn)
            rate_d = ppm_pkg::rate_off;
        else if (i_payload == ppm_pkg::pl_otu2e)
            rate_d = ppm_pkg::rate_otu2_oc_fs;
        else if (eth && reg_f)
            rate_d = ppm_pkg::rate_otu2_oc_fs;
        else if (eth)
            rate_d = i_fixed_stuff ? ppm_pkg::rate_otu2_oc_fs
                                   : ppm_pkg::rate_otu2_oc_nofs; // R9
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_rate          <= ppm_pkg::rate_off;
            o_client_otu2e  <= 1'b0;
            o_trunk_otu2e   <= 1'b0;
            o_odu_terminate <= 1'b0;
            o_odu_passthru  <= 1'b0;
            o_otn_active    <= 1'b0;
        end
        else
        begin
            o_rate          <= rate_d;
            o_client_otu2e  <= otn && ((reg_f && eth) || i_payload == ppm_pkg::pl_otu2e); // R16
            o_trunk_otu2e   <= otn && ((!reg_f && eth && i_fixed_stuff) // R15 R10
                                       || (reg_f && eth) || i_payload == ppm_pkg::pl_otu2e);
            o_odu_terminate <= otn && reg_f && (i_odu != ppm_pkg::odu_transparent); // R19
            o_odu_passthru  <= otn && reg_f && (i_odu == ppm_pkg::odu_transparent); // R20
            o_otn_active    <= otn;
        end
    end

endmodule : ppm_pair_out

/* design/ppm_mode_ctrl.sv */
// Notes on behaviour
// [R1] Reset leaves both pairs as transponders, the default card mode.
// [R2] A card mode with both pairs as regenerators exists.
// [R3] Pairs may differ in function only in one of the two mixed modes.
// [R4] A mixed request naming the same function for both pairs is refused.
// [R5] Provisioning one port of a pair creates its partner port as well.
// [R6] Enhanced FEC is allowed on ports 3 and 4 only.
// [R7] A pair turning regenerator resets ports 3 and 4 to standard FEC.
// [R8] SONET clients run the trunk at the standard 10.70923 Gbps.
// [R9] LAN PHY clients run the trunk at 11.0491 or 11.0957 Gbps.
// [R10] Fixed stuff only for transponder with ten gig ethernet; default on, gives OTU2e.
// [R11] A newly provisioned pair comes up as transponder.
// [R12] From transponder the card may move to regenerator or mixed.
// [R13] Dual regenerator with one pair set: provisioning the other gives mixed.
// [R14] Payload changes on a regenerator pair are refused.
// [R15] Transponder with ten gig ethernet makes trunks 3 and 4 OTU2e.
// [R16] Regenerator with ten gig ethernet makes every port OTU2e; the code sets only the client and trunk port of that regenerator pair.
// [R17] Framing off is taken in transponder mode and removes OTU and ODU.
// [R18] No card mode change while an affected port is in service.
// [R19] Without transparency ODU overhead is terminated and regenerated.
// [R20] With transparency ODU overhead passes unchanged between trunks.
// [R21] Transparency is settable in dual regenerator only; elsewhere interop none.
// [R22] Only ethernet, OTU2, OTU2e, OC192 and STM64 payloads are accepted.
// [R23] A refused request changes nothing and raises a readable reject flag.
`include "ppm_defs.svh"
`timescale 1ns/1ps

module ppm_mode_ctrl #(
    parameter int NUM_PAIRS = `PPM_NUM_PAIRS
) (
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_req_valid,
    input  ppm_pkg::ppm_cmd_t       i_req_cmd,
    input  wire logic [1:0]         i_req_port,
    input  wire logic [2:0]         i_req_arg,
    input  ppm_pkg::ppm_payload_t   i_req_payload,
    input  wire logic [3:0]         i_in_service,
    input  wire logic               i_reject_clear,
    output logic                    o_ack,
    output logic                    o_reject,
    output ppm_pkg::ppm_rej_t       o_reject_reason,
    output logic                    o_reject_flag,
    output ppm_pkg::ppm_card_mode_t o_card_mode,
    output logic [3:0]              o_port_created,
    output logic [3:0]              o_enh_fec,
    output logic [1:0]              o_fixed_stuff,
    output logic                    o_framing_off,
    output ppm_pkg::ppm_odu_t       o_odu_mode,
    output ppm_pkg::ppm_rate_t      o_trunk_rate [2],
    output logic [3:0]              o_port_otu2e,
    output logic [1:0]              o_odu_terminate,
    output logic [1:0]              o_odu_passthru,
    output logic [1:0]              o_otn_active
);

    initial
    begin
        if (NUM_PAIRS != 2)
            $error("ppm_mode_ctrl serves exactly two port pairs");
    end

    // mode of a pair out of a card mode; pair 0 is ports 1 and 3
    function automatic ppm_pkg::ppm_func_t func_of(input ppm_pkg::ppm_card_mode_t m,
                                                   input logic p);
        logic r;
        case (m)
            ppm_pkg::dual_regenerator_mode:        r = 1'b1;
            ppm_pkg::mixed_first_pair_transponder: r = p;
            ppm_pkg::mixed_first_pair_regenerator: r = !p;
            default:                               r = 1'b0;
        endcase
        return r ? ppm_pkg::func_regenerator : ppm_pkg::func_transponder;
    endfunction : func_of

    function automatic ppm_pkg::ppm_card_mode_t mode_of(input logic r0, input logic r1);
        ppm_pkg::ppm_card_mode_t m;
        case ({r0, r1})
            2'b11:   m = ppm_pkg::dual_regenerator_mode;
            2'b01:   m = ppm_pkg::mixed_first_pair_transponder;
            2'b10:   m = ppm_pkg::mixed_first_pair_regenerator;
            default: m = ppm_pkg::dual_transponder_mode;
        endcase
        return m;
    endfunction : mode_of

    ppm_pkg::ppm_card_mode_t mode_q;
    ppm_pkg::ppm_card_mode_t mode_d;
    logic [1:0]              prov_q;
    logic [1:0]              prov_d;
    ppm_pkg::ppm_payload_t   pl_q [2];
    ppm_pkg::ppm_payload_t   pl_d [2];
    logic [3:0]              efec_q;
    logic [3:0]              efec_d;
    logic [1:0]              fs_q;
    logic [1:0]              fs_d;
    logic                    off_q;
    logic                    off_d;
    ppm_pkg::ppm_odu_t       odu_q;
    ppm_pkg::ppm_odu_t       odu_d;
    ppm_pkg::ppm_rej_t       rej;
    logic                    acc;
    logic                    pair;
    logic                    flag;
    logic [1:0]              reg_now;
    logic [1:0]              reg_new;
    logic [3:0]              chg_ports;
    logic [1:0]              client_otu2e;
    logic [1:0]              trunk_otu2e;

    assign pair    = i_req_port[0];
    assign flag    = i_req_arg[`PPM_ARG_FLAG_BIT];
    assign reg_now = {func_of(mode_q, 1'b1) == ppm_pkg::func_regenerator,
                      func_of(mode_q, 1'b0) == ppm_pkg::func_regenerator};
    // ports touched by a mode request: both ports of each pair that changes
    assign chg_ports = {2{reg_now ^ {i_req_arg[`PPM_ARG_FUNC1_BIT],
                                     i_req_arg[`PPM_ARG_FUNC0_BIT]}}};

    // request check and next state; a refusal leaves every *_d at its _q
    always_comb
    begin
        rej    = ppm_pkg::rej_none;
        mode_d = mode_q;
        prov_d = prov_q;
        pl_d   = pl_q;
        efec_d = efec_q;
        fs_d   = fs_q;
        off_d  = off_q;
        odu_d  = odu_q;
        if (i_req_valid)
        begin
            case (i_req_cmd)
                ppm_pkg::cmd_set_mode:
                begin
                    if (i_req_arg[`PPM_ARG_MIXED_BIT] &&
                        i_req_arg[`PPM_ARG_FUNC0_BIT] == i_req_arg[`PPM_ARG_FUNC1_BIT])
                        rej = ppm_pkg::rej_mode_combo; // R4
                    else if (!i_req_arg[`PPM_ARG_MIXED_BIT] &&
                        i_req_arg[`PPM_ARG_FUNC0_BIT] != i_req_arg[`PPM_ARG_FUNC1_BIT])
                        rej = ppm_pkg::rej_mode_combo; // R3
                    else if (|(chg_ports & i_in_service))
                        rej = ppm_pkg::rej_in_service; // R18
                    else
                        mode_d = mode_of(i_req_arg[`PPM_ARG_FUNC0_BIT],
                                         i_req_arg[`PPM_ARG_FUNC1_BIT]); // R2 R12
                end
                ppm_pkg::cmd_provision:
                begin
                    if (i_req_payload == ppm_pkg::pl_none ||
                        i_req_payload == ppm_pkg::pl_fc10g ||
                        i_req_payload == ppm_pkg::pl_ib5)
                        rej = ppm_pkg::rej_payload; // R22
                    else if (reg_now[pair] && prov_q[pair])
                        rej = ppm_pkg::rej_rate_locked; // R14
                    else
                    begin
                        prov_d[pair] = 1'b1; // R5
                        pl_d[pair]   = i_req_payload;
                        if (!prov_q[pair])
                        begin
                            // fresh pair starts as transponder, other pair untouched
                            mode_d = pair ? mode_of(reg_now[0], 1'b0)
                                          : mode_of(1'b0, reg_now[1]); // R11 R13
                            fs_d[pair] = `PPM_FIXED_STUFF_RST;
                        end
                    end
                end
                ppm_pkg::cmd_release:
                begin
                    if (i_in_service[pair] || i_in_service[{1'b1, pair}])
                        rej = ppm_pkg::rej_in_service;
                    else
                    begin
                        prov_d[pair] = 1'b0;
                        pl_d[pair]   = ppm_pkg::pl_none;
                    end
                end
                ppm_pkg::cmd_set_fec:
                begin
                    if (flag && !i_req_port[1])
                        rej = ppm_pkg::rej_fec_port; // R6
                    else
                        efec_d[i_req_port] = flag;
                end
                ppm_pkg::cmd_fixed_stuff:
                begin
                    if (!reg_now[pair] && pl_q[pair] == ppm_pkg::ten_gig_ethernet_payload)
                        fs_d[pair] = flag; // R10
                    else
                        rej = ppm_pkg::rej_not_allowed;
                end
                ppm_pkg::cmd_framing_off:
                begin
                    if (mode_q == ppm_pkg::dual_transponder_mode)
                        off_d = flag; // R17
                    else
                        rej = ppm_pkg::rej_not_allowed;
                end
                ppm_pkg::cmd_odu_transp:
                begin
                    if (mode_q == ppm_pkg::dual_regenerator_mode)
                        odu_d = flag ? ppm_pkg::odu_transparent : ppm_pkg::odu_extended;
                    else
                        rej = ppm_pkg::rej_not_allowed; // R21
                end
                default: rej = ppm_pkg::rej_not_allowed;
            endcase
        end
        // side effects of a mode change; reg_new is set here so no assign loops back
        reg_new = {func_of(mode_d, 1'b1) == ppm_pkg::func_regenerator,
                   func_of(mode_d, 1'b0) == ppm_pkg::func_regenerator};
        if (|(reg_new & ~reg_now))
            efec_d[3:2] = 2'b00; // R7
        if (mode_d != ppm_pkg::dual_transponder_mode)
            off_d = 1'b0;
        if (mode_d != ppm_pkg::dual_regenerator_mode)
            odu_d = ppm_pkg::odu_interop_none; // R21
        else if (mode_q != ppm_pkg::dual_regenerator_mode)
            odu_d = ppm_pkg::odu_extended;
    end

    assign acc     = i_req_valid && (rej == ppm_pkg::rej_none);

    // card mode; refused requests never reach the state
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            mode_q <= ppm_pkg::dual_transponder_mode; // R1
        else if (acc)
            mode_q <= mode_d; // R23
    end

    // provisioning and payloads
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            prov_q <= `PPM_PROV_RST;
            pl_q   <= '{ppm_pkg::pl_none, ppm_pkg::pl_none};
        end
        else if (acc)
        begin
            prov_q <= prov_d;
            pl_q   <= pl_d;
        end
    end

    // fec, fixed stuff, framing off and odu handling
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            efec_q <= `PPM_ENH_FEC_RST;
            fs_q   <= {2{`PPM_FIXED_STUFF_RST}};
            off_q  <= `PPM_FRAMING_OFF_RST;
            odu_q  <= ppm_pkg::odu_interop_none;
        end
        else if (acc)
        begin
            efec_q <= efec_d;
            fs_q   <= fs_d;
            off_q  <= off_d;
            odu_q  <= odu_d;
        end
    end

    // one answer pulse per request, the cycle after it is taken
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_ack           <= 1'b0;
            o_reject        <= 1'b0;
            o_reject_reason <= ppm_pkg::rej_none;
        end
        else
        begin
            o_ack    <= acc;
            o_reject <= i_req_valid && !acc; // R23
            if (i_req_valid)
                o_reject_reason <= rej;
        end
    end

    ppm_sticky u_reject_flag (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_set    (i_req_valid && !acc),
        .i_clear  (i_reject_clear),
        .o_flag   (o_reject_flag)
    );

    // one derivation per pair; pair 0 owns ports 1 and 3
    for (genvar p = 0; p < 2; p++)
    begin : g_pair
        ppm_pair_out u_out (
            .i_clk           (i_clk),
            .i_resetn        (i_resetn),
            .i_func          (func_of(mode_q, p[0])),
            .i_prov          (prov_q[p]),
            .i_payload       (pl_q[p]),
            .i_fixed_stuff   (fs_q[p]),
            .i_framing_off   (off_q),
            .i_odu           (odu_q),
            .o_rate          (o_trunk_rate[p]),
            .o_client_otu2e  (client_otu2e[p]),
            .o_trunk_otu2e   (trunk_otu2e[p]),
            .o_odu_terminate (o_odu_terminate[p]),
            .o_odu_passthru  (o_odu_passthru[p]),
            .o_otn_active    (o_otn_active[p])
        );
    end

    assign o_card_mode    = mode_q;
    assign o_port_created = {prov_q, prov_q}; // R5
    assign o_enh_fec      = efec_q;
    assign o_fixed_stuff  = fs_q;
    assign o_framing_off  = off_q;
    assign o_odu_mode     = odu_q;
    assign o_port_otu2e   = {trunk_otu2e, client_otu2e};

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_mode_req;
        i_req_valid && i_req_cmd == ppm_pkg::cmd_set_mode;
    endsequence
    sequence s_prov_req;
        i_req_valid && i_req_cmd == ppm_pkg::cmd_provision;
    endsequence
    sequence s_refused;
        o_reject && !o_ack && o_reject_flag;
    endsequence

    property p_mixed_combo;
        s_mode_req ##0 (i_req_arg[`PPM_ARG_MIXED_BIT] &&
            i_req_arg[`PPM_ARG_FUNC0_BIT] == i_req_arg[`PPM_ARG_FUNC1_BIT])
            |=> s_refused ##0 o_card_mode == $past(o_card_mode);
    endproperty
    a_mixed_combo: assert property (p_mixed_combo) // R4
        else $error("mixed request with equal functions not refused");

    property p_plain_combo;
        s_mode_req ##0 (!i_req_arg[`PPM_ARG_MIXED_BIT] &&
            i_req_arg[`PPM_ARG_FUNC0_BIT] != i_req_arg[`PPM_ARG_FUNC1_BIT])
            |=> s_refused;
    endproperty
    a_plain_combo: assert property (p_plain_combo) // R3
        else $error("differing functions outside mixed mode not refused");

    property p_in_service;
        s_mode_req ##0 (|(chg_ports & i_in_service))
            |=> o_reject && o_card_mode == $past(o_card_mode);
    endproperty
    a_in_service: assert property (p_in_service) // R18
        else $error("mode changed while an affected port is in service");

    property p_bad_payload;
        s_prov_req ##0 (i_req_payload == ppm_pkg::pl_fc10g ||
            i_req_payload == ppm_pkg::pl_ib5) |=> s_refused ##0 $stable(o_port_created);
    endproperty
    a_bad_payload: assert property (p_bad_payload) // R22
        else $error("unsupported payload accepted");

    property p_rate_locked;
        s_prov_req ##0 (reg_now[pair] && prov_q[pair]) |=> o_reject;
    endproperty
    a_rate_locked: assert property (p_rate_locked) // R14
        else $error("payload change on a regenerator pair accepted");

    property p_regen_fec;
        acc && |(reg_new & ~reg_now) |=> o_enh_fec[3:2] == 2'b00;
    endproperty
    a_regen_fec: assert property (p_regen_fec) // R7
        else $error("trunk fec not standard after switch to regenerator");

    property p_client_fec;
        o_enh_fec[1:0] == 2'b00;
    endproperty
    a_client_fec: assert property (p_client_fec) // R6
        else $error("enhanced fec on port 1 or 2");

    property p_odu_forced;
        o_card_mode != ppm_pkg::dual_regenerator_mode |-> o_odu_mode == ppm_pkg::odu_interop_none;
    endproperty
    a_odu_forced: assert property (p_odu_forced) // R21
        else $error("odu transparency not interop none outside dual regenerator");

    property p_new_pair_xp;
        s_prov_req ##0 (mode_q == ppm_pkg::dual_regenerator_mode && !prov_q[pair]
            && prov_q[!pair] && rej == ppm_pkg::rej_none)
            |=> o_ack ##0 o_card_mode != ppm_pkg::dual_regenerator_mode;
    endproperty
    a_new_pair_xp: assert property (p_new_pair_xp) // R13
        else $error("provisioning other pair did not give mixed mode");

    property p_framing_off;
        o_framing_off |=> o_otn_active == 2'b00 && o_odu_terminate == 2'b00;
    endproperty
    a_framing_off: assert property (p_framing_off) // R17
        else $error("otn interfaces present with framing off");

    property p_partner;
        o_port_created[1:0] == o_port_created[3:2];
    endproperty
    a_partner: assert property (p_partner) // R5
        else $error("port created without its partner");

endmodule : ppm_mode_ctrl

/* testbench/ppm_mgr_model.sv */
`timescale 1ns/1ps

// management side: one request at a time, answer sampled one cycle later
module ppm_mgr_model (
    input  wire logic             i_clk,
    input  wire logic             i_ack,
    input  wire logic             i_reject,
    output logic                  o_req_valid,
    output ppm_pkg::ppm_cmd_t     o_req_cmd,
    output logic [1:0]            o_req_port,
    output logic [2:0]            o_req_arg,
    output ppm_pkg::ppm_payload_t o_req_payload
);
    // idle fields start scrambled, and port and arg are inverted after each request, so nothing can lean on a stale request
    initial
    begin
        o_req_valid   = 1'b0;
        o_req_cmd     = ppm_pkg::cmd_release;
        o_req_port    = 2'h3;
        o_req_arg     = 3'h7;
        o_req_payload = ppm_pkg::pl_ib5;
    end

    task automatic send(input ppm_pkg::ppm_cmd_t c, input logic [1:0] p, input logic [2:0] a,
                        input ppm_pkg::ppm_payload_t pl, output logic ack, output logic rej);
        @(negedge i_clk);
        o_req_valid   = 1'b1;
        o_req_cmd     = c;
        o_req_port    = p;
        o_req_arg     = a;
        o_req_payload = pl;
        @(negedge i_clk);
        // the answer stands only in the cycle after the taking edge
        ack = i_ack;
        rej = i_reject;
        o_req_valid = 1'b0;
        o_req_port  = ~p;
        o_req_arg   = ~a;
    endtask : send
endmodule : ppm_mgr_model

/* testbench/testbench.sv */
`timescale 1ns/1ps

module testbench;
    typedef struct {
        ppm_pkg::ppm_cmd_t c; logic [1:0] p; logic [2:0] a;
        ppm_pkg::ppm_payload_t pl; logic k; ppm_pkg::ppm_card_mode_t m;
    } ppm_row_t;
    localparam ppm_pkg::ppm_cmd_t pv = ppm_pkg::cmd_provision;
    localparam ppm_pkg::ppm_cmd_t sm = ppm_pkg::cmd_set_mode;
    localparam ppm_pkg::ppm_cmd_t fe = ppm_pkg::cmd_set_fec;
    localparam ppm_pkg::ppm_card_mode_t xp = ppm_pkg::dual_transponder_mode;
    localparam ppm_pkg::ppm_card_mode_t rg = ppm_pkg::dual_regenerator_mode;
    localparam ppm_pkg::ppm_payload_t tg = ppm_pkg::ten_gig_ethernet_payload;
    localparam ppm_pkg::ppm_payload_t no = ppm_pkg::pl_none;
    logic clk = 1'b0, resetn = 1'b0, clr = 1'b0, ack, rej, vld, fl, fo;
    logic [3:0] ins = 4'h0, cre, efec, otu2e;
    logic [2:0] arg;
    logic [1:0] port, fs, t0, t1, t2;
    ppm_pkg::ppm_cmd_t cmd;
    ppm_pkg::ppm_payload_t pl;
    ppm_pkg::ppm_card_mode_t mode;
    ppm_pkg::ppm_rej_t why;
    ppm_pkg::ppm_odu_t odu;
    ppm_pkg::ppm_rate_t rate [2];
    logic a_q, r_q;
    int bad_count = 0, checks_done = 0;
    ppm_row_t rows [11];

    always #2 clk = ~clk;

    ppm_mgr_model mgr (.i_clk(clk), .i_ack(a_q), .i_reject(r_q), .o_req_valid(vld),
        .o_req_cmd(cmd), .o_req_port(port), .o_req_arg(arg), .o_req_payload(pl));
    ppm_mode_ctrl uut (.i_clk(clk), .i_resetn(resetn), .i_req_valid(vld), .i_req_cmd(cmd),
        .i_req_port(port), .i_req_arg(arg), .i_req_payload(pl), .i_in_service(ins),
        .i_reject_clear(clr), .o_ack(a_q), .o_reject(r_q), .o_reject_reason(why),
        .o_reject_flag(fl), .o_card_mode(mode), .o_port_created(cre), .o_enh_fec(efec),
        .o_fixed_stuff(fs), .o_framing_off(fo), .o_odu_mode(odu), .o_trunk_rate(rate),
        .o_port_otu2e(otu2e), .o_odu_terminate(t0), .o_odu_passthru(t1), .o_otn_active(t2));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // watchdog: the whole run needs well under 200 cycles
    initial
    begin
        #4000;
        bad_count++;
        stop_test();
    end

    initial
    begin
        rows = '{'{pv, 2'h0, 3'h0, tg, 1, xp}, '{pv, 2'h1, 3'h0, ppm_pkg::pl_fc10g, 0, xp},
            '{pv, 2'h1, 3'h0, ppm_pkg::pl_stm64, 1, xp}, '{fe, 2'h0, 3'h1, no, 0, xp},
            '{sm, 2'h0, 3'h4, no, 0, xp}, '{sm, 2'h0, 3'h6, no, 1,
            ppm_pkg::mixed_first_pair_regenerator}, '{sm, 2'h0, 3'h0, no, 1, xp},
            '{sm, 2'h0, 3'h3, no, 1, rg}, '{pv, 2'h0, 3'h0, ppm_pkg::pl_oc192, 0, rg},
            '{fe, 2'h2, 3'h1, no, 1, rg}, '{ppm_pkg::cmd_odu_transp, 2'h0, 3'h1, no, 1, rg}};
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        // rows: in table order
        for (int i = 0; i < 11; i++)
        begin
            mgr.send(rows[i].c, rows[i].p, rows[i].a, rows[i].pl, ack, rej);
            chk({ack, rej}, {rows[i].k, ~rows[i].k});
            chk(mode, rows[i].m);
        end
        chk(cre, 4'hf);
        chk(efec, 4'h4);
        chk(rate[0], ppm_pkg::rate_otu2_oc_fs);
        chk(rate[1], ppm_pkg::rate_otu2_std);
        chk(otu2e, 4'h5);
        chk(odu, ppm_pkg::odu_transparent);
        // per-pair outputs lag the state by one more cycle
        @(negedge clk);
        chk({t0, t1, t2}, 6'h0f);
        // in-service port blocks the mode change and leaves a sticky flag
        ins = 4'h1;
        mgr.send(sm, 2'h0, 3'h0, no, ack, rej);
        chk({rej, fl, mode, why}, {2'b11, rg, ppm_pkg::rej_in_service});
        ins = 4'h0;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        chk(fl, 1'b0);
        mgr.send(ppm_pkg::cmd_odu_transp, 2'h0, 3'h0, no, ack, rej);
        @(negedge clk);
        chk({t0, t1}, 4'hc);
        // reset in mid-run returns to the default card mode
        resetn = 1'b0;
        @(negedge clk);
        chk({mode, cre, fs, odu}, {xp, 4'h0, 2'b11, ppm_pkg::odu_interop_none});
        resetn = 1'b1;
        mgr.send(pv, 2'h0, 3'h0, tg, ack, rej);
        @(negedge clk);
        chk({rate[0], otu2e}, {ppm_pkg::rate_otu2_oc_fs, 4'h4});
        mgr.send(ppm_pkg::cmd_fixed_stuff, 2'h0, 3'h0, no, ack, rej);
        @(negedge clk);
        chk({rate[0], otu2e}, {ppm_pkg::rate_otu2_oc_nofs, 4'h0});
        // framing off strips the pair; leaving transponder clears it again
        mgr.send(ppm_pkg::cmd_framing_off, 2'h0, 3'h1, no, ack, rej);
        @(negedge clk);
        chk({fo, t2, rate[0]}, {1'b1, 2'b00, ppm_pkg::rate_off});
        mgr.send(sm, 2'h0, 3'h3, no, ack, rej);
        mgr.send(pv, 2'h1, 3'h0, ppm_pkg::pl_stm64, ack, rej);
        chk({ack, fo, mode}, {2'b10, ppm_pkg::mixed_first_pair_regenerator});
        mgr.send(ppm_pkg::cmd_release, 2'h1, 3'h0, no, ack, rej);
        chk(cre, 4'h5);
        stop_test();
    end
endmodule : testbench
